/* shared/dai_pkg.sv */
// constants and carrier types of the ds3 alarm and loopback irq block
package dai_pkg;
    localparam logic [7:0] ADDR_AIS_SEL   = 8'h21;
    localparam logic [7:0] ADDR_ALARM     = 8'h24;
    localparam logic [7:0] ADDR_REQ_A     = 8'h25;
    localparam logic [7:0] ADDR_REQ_B     = 8'h26;
    localparam logic [7:0] ADDR_MASK_A    = 8'h2E;
    localparam logic [7:0] ADDR_MASK_B    = 8'h2F;
    localparam logic [7:0] ADDR_EV_STAT   = 8'h3C;
    localparam logic [7:0] ADDR_EV_MASK   = 8'h3D;
    localparam logic [7:0] ADDR_EDGE      = 8'h3F;
    // alarm register bit positions
    localparam int         XONES_BIT      = 7;
    localparam int         CZERO_BIT      = 6;
    localparam int         SEF_BIT        = 0;
    // edge select bit positions and reset value
    localparam int         EDGE_RISE_BIT  = 1;
    localparam int         EDGE_FALL_BIT  = 0;
    localparam logic [7:0] EDGE_RST       = 8'h02;
    // event status bit positions
    localparam int         EV_SEF_BIT     = 0;
    localparam int         EV_XONES_BIT   = 1;
    localparam int         EV_CZERO_BIT   = 2;
    localparam logic [2:0] EV_USED        = 3'h7;
    // filter figures
    localparam logic [3:0] ONES_MATURE    = 4'hF;
    localparam logic [1:0] ZEROS_MATURE   = 2'h3;
    localparam logic [2:0] CFRAMES_NEED   = 3'h7;
    localparam logic [4:0] CONES_LIMIT    = 5'h1E;
    localparam int         FWIN_LEN       = 16;
    localparam logic [4:0] FERR_LIMIT     = 5'h03;
    localparam logic [2:0] SEL_XONES      = 3'h1;
    localparam logic [1:0] PAIR_ONES      = 2'h3;
    localparam logic [1:0] PAIR_ZEROS     = 2'h0;
    localparam logic [7:0] REG_ZERO       = 8'h00;

    // processor access, one strobe per cycle
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dai_bus_s;

    // end of received M-frame summary
    typedef struct packed {
        logic       done;
        logic       ok;
        logic [1:0] xPair;
        logic [4:0] cOnes;
    } dai_frame_s;

    // one received F-bit
    typedef struct packed {
        logic valid;
        logic err;
        logic inFrame;
    } dai_fbit_s;
endpackage : dai_pkg

/* hw/dai_alarm_irq.sv */
// receive ds3 alarm latches and loopback interrupt requests
`timescale 1ns/100ps
module dai_alarm_irq
    import dai_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire dai_bus_s   bus,
    output logic      [7:0] rdData,
    input  wire dai_frame_s frame,
    input  wire dai_fbit_s  fbit,
    input  wire logic [7:0] loopCondA,
    input  wire logic [7:0] loopCondB,
    output logic            irq,
    output logic            xbitsAisCond,
    output logic            cbitsAisCond,
    output logic            sefActive
);
    logic [3:0]  onesCnt;
    logic [1:0]  zerosCnt;
    logic        xOnesState;
    logic [2:0]  cRun;
    logic [FWIN_LEN-1:0] fWin;
    logic [4:0]  errCnt;
    logic [4:0]  next_errCnt;
    logic        sefState;
    logic        xOnesLatch;
    logic        cZeroLatch;
    logic        sefLatch;
    logic [2:0]  aisSel;
    logic [7:0]  maskA;
    logic [7:0]  maskB;
    logic [7:0]  edgeSel;
    logic [7:0]  reqA;
    logic [7:0]  reqB;
    logic [15:0] condPrev;
    logic [15:0] reqSet;
    logic [2:0]  evStat;
    logic [2:0]  evMask;
    logic        pairEval;
    logic        onesMature;
    logic        zerosMature;
    logic        cGood;
    logic        sefRise;
    logic        cRise;
    logic        rdAlarm;
    logic        rdReqA;
    logic        rdReqB;
    logic [7:0]  next_reqA;
    logic [7:0]  next_reqB;
    logic [2:0]  next_evStat;
    logic [7:0]  rdMux;

    // pair evaluation strobes, only on a valid frame
    assign pairEval    = frame.done & frame.ok;
    assign onesMature  = pairEval & (frame.xPair == PAIR_ONES)
                         & (onesCnt == ONES_MATURE);
    assign zerosMature = pairEval & (frame.xPair == PAIR_ZEROS)
                         & (zerosCnt == ZEROS_MATURE);
    assign cGood       = frame.cOnes <= CONES_LIMIT;
    assign rdAlarm     = bus.rd & (bus.addr == ADDR_ALARM);
    assign rdReqA      = bus.rd & (bus.addr == ADDR_REQ_A);
    assign rdReqB      = bus.rd & (bus.addr == ADDR_REQ_B);

    // x-bit ones and zeros filter counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            onesCnt  <= 4'h0;
            zerosCnt <= 2'h0;
        end else if (onesMature || zerosMature) begin
            onesCnt  <= 4'h0;
            zerosCnt <= 2'h0;
        end else if (pairEval && frame.xPair == PAIR_ONES) begin
            onesCnt  <= 4'(onesCnt + 4'h1);
        end else if (pairEval && frame.xPair == PAIR_ZEROS) begin
            zerosCnt <= 2'(zerosCnt + 2'h1);
        end
    end

    // filtered x-ones level: held until zeros side matures
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xOnesState <= 1'b0;
        end else if (onesMature) begin
            xOnesState <= 1'b1;
        end else if (zerosMature) begin
            xOnesState <= 1'b0;
        end
    end

    // run of frames with few c-bits at one, saturates at seven
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cRun <= 3'h0;
        end else if (frame.done) begin
            if (!frame.ok || !cGood) begin
                cRun <= 3'h0;
            end else if (cRun != CFRAMES_NEED) begin
                cRun <= 3'(cRun + 3'h1);
            end
        end
    end
    assign cRise = frame.done & frame.ok & cGood
                   & (cRun == 3'(CFRAMES_NEED - 3'h1));

    // sliding f-bit window, running error count
    always_comb begin
        next_errCnt = errCnt;
        if (fbit.valid) begin
            next_errCnt = 5'(errCnt + {4'h0, fbit.err}
                             - {4'h0, fWin[FWIN_LEN-1]});
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fWin   <= '0;
            errCnt <= 5'h0;
        end else if (fbit.valid) begin
            fWin   <= {fWin[FWIN_LEN-2:0], fbit.err};
            errCnt <= next_errCnt;
        end
    end

    // defect begins at three errors, ends in frame under three
    assign sefRise = !sefState && next_errCnt >= FERR_LIMIT;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sefState <= 1'b0;
        end else if (next_errCnt >= FERR_LIMIT) begin
            sefState <= 1'b1;
        end else if (fbit.valid && fbit.inFrame) begin
            sefState <= 1'b0;
        end
    end

    // latched alarm bits: read clears, live cause sets again
    // set terms win over the read so no event slips through
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xOnesLatch <= 1'b0;
            cZeroLatch <= 1'b0;
            sefLatch   <= 1'b0;
        end else begin
            xOnesLatch <= (xOnesLatch & ~rdAlarm) | onesMature
                          | xOnesState;
            cZeroLatch <= (cZeroLatch & ~rdAlarm) | cRise
                          | (cRun == CFRAMES_NEED);
            sefLatch   <= (sefLatch & ~rdAlarm) | sefRise
                          | sefState;
        end
    end

    // ais condition outputs for the downstream ais decoder
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xbitsAisCond <= 1'b0;
            cbitsAisCond <= 1'b0;
            sefActive    <= 1'b0;
        end else begin
            xbitsAisCond <= (aisSel == SEL_XONES) & xOnesLatch;
            cbitsAisCond <= (aisSel[2:1] == 2'h0) & cZeroLatch;
            sefActive    <= sefState;
        end
    end

    // software written control registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aisSel  <= 3'h0;
            maskA   <= REG_ZERO;
            maskB   <= REG_ZERO;
            edgeSel <= EDGE_RST;
            evMask  <= 3'h0;
        end else if (bus.wr) begin
            unique case (bus.addr)
                ADDR_AIS_SEL: aisSel  <= bus.wdata[2:0];
                ADDR_MASK_A:  maskA   <= bus.wdata;
                ADDR_MASK_B:  maskB   <= bus.wdata;
                ADDR_EDGE:    edgeSel <= bus.wdata;
                ADDR_EV_MASK: evMask  <= bus.wdata[2:0];
                default: ;
            endcase
        end
    end

    // per bit edge detection of the loopback request conditions
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            condPrev <= 16'h0000;
        end else begin
            condPrev <= {loopCondB, loopCondA};
        end
    end

    for (genvar i = 0; i < 16; i++) begin : g_edge
        logic cur;
        assign cur = (i < 8) ? loopCondA[i % 8] : loopCondB[i % 8];
        assign reqSet[i] =
            (edgeSel[EDGE_RISE_BIT] & cur & ~condPrev[i])
            | (edgeSel[EDGE_FALL_BIT] & ~cur & condPrev[i]);
    end

    // request registers: bit 7 all-channel or ds3, 6..0 channels
    assign next_reqA = (reqA & {8{~rdReqA}}) | reqSet[7:0];
    assign next_reqB = (reqB & {8{~rdReqB}}) | reqSet[15:8];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reqA <= REG_ZERO;
            reqB <= REG_ZERO;
        end else begin
            reqA <= next_reqA;
            reqB <= next_reqB;
        end
    end

    // sticky events, write one to clear, set wins
    always_comb begin
        next_evStat = evStat;
        if (bus.wr && bus.addr == ADDR_EV_STAT) begin
            next_evStat = evStat & ~bus.wdata[2:0];
        end
        next_evStat[EV_SEF_BIT]   = next_evStat[EV_SEF_BIT] | sefRise;
        next_evStat[EV_XONES_BIT] = next_evStat[EV_XONES_BIT]
                                    | onesMature;
        next_evStat[EV_CZERO_BIT] = next_evStat[EV_CZERO_BIT] | cRise;
        next_evStat = next_evStat & EV_USED;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evStat <= 3'h0;
        end else begin
            evStat <= next_evStat;
        end
    end

    // one level interrupt, registered from next state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_reqA & maskA) | |(next_reqB & maskB)
                   | |(next_evStat & evMask);
        end
    end

    // read mux; test and reserved bits read zero
    always_comb begin
        rdMux = REG_ZERO;
        unique case (bus.addr)
            ADDR_ALARM: begin
                rdMux[XONES_BIT] = xOnesLatch;
                rdMux[CZERO_BIT] = cZeroLatch;
                rdMux[SEF_BIT]   = sefLatch;
            end
            ADDR_REQ_A:   rdMux = reqA;
            ADDR_REQ_B:   rdMux = reqB;
            ADDR_AIS_SEL: rdMux = {5'h00, aisSel};
            ADDR_MASK_A:  rdMux = maskA;
            ADDR_MASK_B:  rdMux = maskB;
            ADDR_EDGE:    rdMux = edgeSel;
            ADDR_EV_STAT: rdMux = {5'h00, evStat};
            ADDR_EV_MASK: rdMux = {5'h00, evMask};
            default:      rdMux = REG_ZERO;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= REG_ZERO;
        end else begin
            rdData <= bus.rd ? rdMux : REG_ZERO;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_ones_step: assert property (
        pairEval && frame.xPair == PAIR_ONES && !onesMature
        |=> onesCnt == 4'($past(onesCnt) + 4'h1))
        else $error("ones pair counter did not advance");

    chk_zeros_step: assert property (
        pairEval && frame.xPair == PAIR_ZEROS && !zerosMature
        |=> zerosCnt == 2'($past(zerosCnt) + 2'h1))
        else $error("zeros pair counter did not advance");

    chk_mature_reset: assert property (
        onesMature || zerosMature |=> onesCnt == 4'h0 && zerosCnt == 2'h0)
        else $error("counters not cleared on maturity");

    chk_xones_latch: assert property (
        onesMature |=> xOnesLatch ##1 xOnesLatch)
        else $error("x ones bit not latched");

    chk_xsel_cond: assert property (
        xOnesLatch && aisSel == SEL_XONES |=> xbitsAisCond)
        else $error("x ones not used as ais condition");

    chk_czero_set: assert property (
        cRise |=> cZeroLatch && cRun == CFRAMES_NEED)
        else $error("c zero bit not set after seven frames");

    chk_csel_cond: assert property (
        cZeroLatch && aisSel[2:1] == 2'h0 |=> cbitsAisCond)
        else $error("c zero not used as ais condition");

    chk_read_relatch: assert property (
        rdAlarm && sefState |=> sefLatch)
        else $error("persisting defect did not relatch");

    chk_sef_window: assert property (
        errCnt >= FERR_LIMIT |-> sefState)
        else $error("three window errors without defect");

    chk_sef_end: assert property (
        sefState && fbit.valid && fbit.inFrame && next_errCnt < FERR_LIMIT
        |=> !sefState)
        else $error("defect did not end");

    chk_rise_set: assert property (
        edgeSel[EDGE_RISE_BIT] && loopCondA[0] && !condPrev[0]
        |=> reqA[0])
        else $error("rising request not latched");

    chk_req_clear: assert property (
        rdReqA && reqSet[7:0] == 8'h00 |=> reqA == 8'h00)
        else $error("request register not cleared by read");

    // irq follows next request state, so a mask write lags one edge
    chk_irq_mask: assert property (
        (next_reqB & maskB) != 8'h00 |=> irq)
        else $error("masked request without interrupt");

    // zeros maturity must pull the filtered x-ones level down
    chk_zeros_clear: assert property (
        zerosMature |=> !xOnesState)
        else $error("zeros maturity left x ones set");

    // any other selection must keep the x-bits condition low
    chk_xsel_off: assert property (
        aisSel != SEL_XONES |=> !xbitsAisCond)
        else $error("x ones used with wrong selection");

    chk_sef_latch: assert property (
        sefRise |=> sefLatch && sefState)
        else $error("defect onset not latched");

    // request mapping and clear checks on the top bits
    chk_all_chan: assert property (
        edgeSel[EDGE_RISE_BIT] && loopCondA[7] && !condPrev[7]
        |=> reqA[7])
        else $error("all channel request not latched");

    chk_ds3_fall: assert property (
        edgeSel[EDGE_FALL_BIT] && !loopCondB[7] && condPrev[15]
        |=> reqB[7])
        else $error("ds3 request not latched on fall");

    chk_req_b_clear: assert property (
        rdReqB && reqSet[15:8] == 8'h00 |=> reqB == 8'h00)
        else $error("request register b not cleared by read");

    // event clear by software must stick unless a new event lands
    chk_ev_clear: assert property (
        bus.wr && bus.addr == ADDR_EV_STAT && bus.wdata[EV_XONES_BIT]
        && !onesMature |=> !evStat[EV_XONES_BIT])
        else $error("event bit not cleared by write");

    // main scenarios the bench is expected to reach
    cov_xones: cover property (onesMature ##[1:40] rdAlarm);
    cov_sef: cover property (sefRise ##[1:100] !sefState);
    cov_req_irq: cover property (reqSet[15] ##1 irq ##[1:20] rdReqB);
    cov_czero_cond: cover property (cRise ##1 cZeroLatch ##1 cbitsAisCond);
    cov_fall_req: cover property (edgeSel[EDGE_FALL_BIT] && reqSet[8]);
endmodule : dai_alarm_irq

/* tb/dai_line_model.sv */
// behavioural ds3 line side: frame summaries and received f-bits
`timescale 1ns/100ps
module dai_line_model
    import dai_pkg::*;
(
    input  wire logic core_clk,
    output dai_frame_s frame,
    output dai_fbit_s  fbit
);
    // idle at time zero, no frame or f-bit offered
    initial begin
        frame = '0;
        fbit  = '0;
    end

    // one summary pulse per m-frame; fields flip when idle so stale
    // values can never be mistaken for a fresh frame
    task automatic send_frame(input logic ok, input logic [1:0] xp,
                              input logic [4:0] co);
        @(posedge core_clk);
        frame <= '{done: 1'b1, ok: ok, xPair: xp, cOnes: co};
        @(posedge core_clk);
        frame <= '{done: 1'b0, ok: ~ok, xPair: ~xp, cOnes: ~co};
    endtask : send_frame

    // one f-bit pulse; frame state is a level and holds
    task automatic send_fbit(input logic err, input logic inFr);
        @(posedge core_clk);
        fbit <= '{valid: 1'b1, err: err, inFrame: inFr};
        @(posedge core_clk);
        fbit <= '{valid: 1'b0, err: ~err, inFrame: inFr};
    endtask : send_fbit
endmodule : dai_line_model

/* tb/dai_alarm_irq_test.sv */
// self-checking bench of the ds3 alarm and loopback irq block
`timescale 1ns/100ps
module dai_alarm_irq_test
    import dai_pkg::*;
;
    logic       core_clk;
    logic       rst_n;
    dai_bus_s   bus;
    logic [7:0] rdData;
    dai_frame_s frame;
    dai_fbit_s  fbit;
    logic [7:0] loopCondA;
    logic [7:0] loopCondB;
    logic       irq;
    logic       xbitsAisCond;
    logic       cbitsAisCond;
    logic       sefActive;
    int         nErrors;
    int         samplesChecked;
    int         cycles;

    dai_alarm_irq dut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus),
        .rdData(rdData), .frame(frame), .fbit(fbit),
        .loopCondA(loopCondA), .loopCondB(loopCondB), .irq(irq),
        .xbitsAisCond(xbitsAisCond), .cbitsAisCond(cbitsAisCond),
        .sefActive(sefActive));
    dai_line_model line (.core_clk(core_clk), .frame(frame), .fbit(fbit));

    // 25 MHz clock
    initial core_clk = 1'b0;
    always #20 core_clk = ~core_clk;

    // hang guard, generous against a run of a few hundred cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nErrors++;
            $display("mismatch at %0t: run timed out", $time);
            end_sim();
        end
    end

    task automatic end_sim();
        $display("errors %0d of %0d checks", nErrors, samplesChecked);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus <= '0;
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp,
                         input logic [7:0] msk, input string msg);
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        bus <= '0;
        #1 chk(rdData & msk, exp & msk, msg);
    endtask : rdChk

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic t_reset();
        logic [7:0] addrs [10];
        addrs = '{ADDR_AIS_SEL, ADDR_ALARM, ADDR_REQ_A, ADDR_REQ_B,
                  ADDR_MASK_A, ADDR_MASK_B, ADDR_EV_STAT, ADDR_EV_MASK,
                  ADDR_EDGE, 8'h10};
        foreach (addrs[i]) begin
            rdChk(addrs[i], (addrs[i] == ADDR_EDGE) ? EDGE_RST : REG_ZERO,
                  8'hFF, "reset value");
        end
        chk({7'h00, irq}, 8'h00, "irq after reset");
    endtask : t_reset

    task automatic t_xones();
        wr(ADDR_AIS_SEL, 8'h01);
        repeat (15) line.send_frame(1'b1, 2'h3, 5'h00);
        line.send_frame(1'b1, 2'h1, 5'h00);
        line.send_frame(1'b0, 2'h3, 5'h00);
        rdChk(ADDR_ALARM, 8'h00, 8'h80, "x-ones early");
        line.send_frame(1'b1, 2'h3, 5'h00);
        rdChk(ADDR_ALARM, 8'h80, 8'hC1, "x-ones set");
        chk({7'h00, xbitsAisCond}, 8'h01, "x ais cond");
        rdChk(ADDR_ALARM, 8'h80, 8'h80, "x-ones relatch");
        rdChk(ADDR_EV_STAT, 8'h02, 8'h02, "event bit");
        chk({7'h00, irq}, 8'h00, "event masked");
        wr(ADDR_EV_MASK, 8'h02);
        cyc(2);
        chk({7'h00, irq}, 8'h01, "event irq");
        wr(ADDR_EV_STAT, 8'h02);
        cyc(2);
        chk({7'h00, irq}, 8'h00, "event cleared");
        wr(ADDR_EV_MASK, 8'h00);
        // zeros count survives ones pairs that do not mature
        repeat (3) line.send_frame(1'b1, 2'h0, 5'h00);
        repeat (3) line.send_frame(1'b1, 2'h3, 5'h00);
        rdChk(ADDR_ALARM, 8'h80, 8'h80, "zeros not matured");
        line.send_frame(1'b1, 2'h0, 5'h00);
        rdChk(ADDR_ALARM, 8'h00, 8'h00, "drain read");
        rdChk(ADDR_ALARM, 8'h00, 8'h80, "x-ones gone");
        repeat (15) line.send_frame(1'b1, 2'h3, 5'h00);
        repeat (4) line.send_frame(1'b1, 2'h0, 5'h00);
        line.send_frame(1'b1, 2'h3, 5'h00);
        rdChk(ADDR_ALARM, 8'h00, 8'h80, "both counters reset");
    endtask : t_xones

    task automatic t_czero();
        repeat (6) line.send_frame(1'b1, 2'h1, 5'h1E);
        line.send_frame(1'b1, 2'h1, 5'h1F);
        rdChk(ADDR_ALARM, 8'h00, 8'h00, "drain read");
        repeat (6) line.send_frame(1'b1, 2'h1, 5'h1E);
        rdChk(ADDR_ALARM, 8'h00, 8'h40, "c-zero early");
        line.send_frame(1'b1, 2'h1, 5'h1E);
        rdChk(ADDR_ALARM, 8'h40, 8'h40, "c-zero set");
        chk({7'h00, cbitsAisCond}, 8'h01, "c ais cond");
        wr(ADDR_AIS_SEL, 8'h04);
        cyc(2);
        chk({7'h00, cbitsAisCond}, 8'h00, "c ais off");
    endtask : t_czero

    task automatic t_sef();
        line.send_fbit(1'b1, 1'b1);
        repeat (13) line.send_fbit(1'b0, 1'b1);
        line.send_fbit(1'b1, 1'b1);
        rdChk(ADDR_ALARM, 8'h00, 8'h01, "sef early");
        line.send_fbit(1'b1, 1'b1);
        rdChk(ADDR_ALARM, 8'h01, 8'h01, "sef set");
        chk({7'h00, sefActive}, 8'h01, "sef defect");
        repeat (16) line.send_fbit(1'b0, 1'b0);
        cyc(2);
        chk({7'h00, sefActive}, 8'h01, "sef out of frame");
        line.send_fbit(1'b0, 1'b1);
        cyc(2);
        chk({7'h00, sefActive}, 8'h00, "sef ended");
        rdChk(ADDR_ALARM, 8'h00, 8'h00, "drain read");
        rdChk(ADDR_ALARM, 8'h00, 8'h01, "sef cleared");
    endtask : t_sef

    task automatic t_loop();
        wr(ADDR_MASK_A, 8'h80);
        @(posedge core_clk) loopCondA <= 8'h01;
        cyc(3);
        chk({7'h00, irq}, 8'h00, "unmasked request");
        @(posedge core_clk) loopCondA <= 8'h81;
        cyc(3);
        chk({7'h00, irq}, 8'h01, "masked request");
        rdChk(ADDR_REQ_A, 8'h81, 8'hFF, "request a");
        cyc(1);
        chk({7'h00, irq}, 8'h00, "irq after read");
        rdChk(ADDR_REQ_A, 8'h00, 8'hFF, "request a cleared");
        @(posedge core_clk) loopCondA <= 8'h00;
        cyc(3);
        rdChk(ADDR_REQ_A, 8'h00, 8'hFF, "fall ignored");
        wr(ADDR_EDGE, 8'h01);
        wr(ADDR_MASK_B, 8'h01);
        @(posedge core_clk) loopCondB <= 8'h81;
        cyc(3);
        rdChk(ADDR_REQ_B, 8'h00, 8'hFF, "rise ignored");
        @(posedge core_clk) loopCondB <= 8'h00;
        cyc(3);
        chk({7'h00, irq}, 8'h01, "fall irq");
        rdChk(ADDR_REQ_B, 8'h81, 8'hFF, "request b");
        wr(ADDR_EDGE, 8'h03);
        @(posedge core_clk) loopCondB <= 8'h02;
        cyc(3);
        rdChk(ADDR_REQ_B, 8'h02, 8'hFF, "both edges rise");
        @(posedge core_clk) loopCondB <= 8'h00;
        cyc(3);
        rdChk(ADDR_REQ_B, 8'h02, 8'hFF, "both edges fall");
    endtask : t_loop

    // main sequence: reset held three cycles, then the scenarios
    initial begin
        rst_n          = 1'b0;
        bus            = '0;
        loopCondA      = 8'h00;
        loopCondB      = 8'h00;
        nErrors        = 0;
        samplesChecked = 0;
        cycles         = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_xones();
        t_czero();
        t_sef();
        t_loop();
        end_sim();
    end
endmodule : dai_alarm_irq_test
